// *** uic_top.sv ***
// Local design decisions: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - type selector enables only its paths
// - analog notch only for voltage/current
// - digital type drives pull network selector
// - logic selector, reset to normal
// - normal: state follows signal
// - inverse: state is inverted signal
// - latched: toggle on off-to-on
// - inverse latched: toggle on on-to-off
// - pulse filter before sampling, four lengths
// - ppr above zero reports rpm
// - analog data filter selector, default none
// - no filter passes latest measurement
// - moving average each millisecond
// - repeating average over N samples
// - range and error limit registers
// - error gated by enable, hysteresis clear
// - error delay copied to all diagnostics
module uic_top #(
  parameter int NDIAG    = 2,
  parameter int TICK_CYC = uic_pkg::TICK_CYC
) (
  input  wire logic                sys_clk,
  input  wire logic                rst_n,
  input  wire logic [5:0]          avs_address,
  input  wire logic                avs_read,
  input  wire logic                avs_write,
  input  wire logic [31:0]         avs_writedata,
  input  wire logic [3:0]          avs_byteenable,
  output logic [31:0]              avs_readdata,
  output logic                     avs_waitrequest,
  input  wire logic                pin_in,
  input  wire logic [31:0]         meas_data,
  input  wire logic                meas_valid,
  output logic                     adc_en,
  output logic [1:0]               adc_notch,
  output logic                     pull_up_en,
  output logic                     pull_down_en,
  output logic                     state_out,
  output logic [31:0]              value_out,
  output logic                     err_out,
  output logic [NDIAG*32-1:0]      diag_delay,
  output logic                     irq
);
  logic [31:0] cfg_r;
  logic [31:0] deb_r;
  logic [31:0] ppr_r;
  logic [31:0] fconst_r;
  logic [31:0] rmin_r;
  logic [31:0] rmax_r;
  logic [31:0] emin_r;
  logic [31:0] emax_r;
  logic [31:0] hyst_r;
  logic [31:0] edly_r;
  logic [2:0]  irq_st_r;
  logic [2:0]  irq_mask_r;
  logic        ack_r;
  logic [31:0] wmask;
  logic        wr_go;
  logic        rd_go;
  logic [31:0] rd_nxt;

  logic [2:0] in_type;
  logic [2:0] logic_sel;
  logic [1:0] dfilt;
  logic [1:0] pwmf;
  logic       err_en;
  logic       is_analog;
  logic       is_dig;
  logic       is_pulse;

  assign in_type   = cfg_r[uic_pkg::CFG_TYPE_LSB +: 3];
  assign logic_sel = cfg_r[uic_pkg::CFG_LOGIC_LSB +: 3];
  assign dfilt     = cfg_r[uic_pkg::CFG_DFILT_LSB +: 2];
  assign pwmf      = cfg_r[uic_pkg::CFG_PWMF_LSB +: 2];
  assign err_en    = cfg_r[uic_pkg::CFG_ERREN_BIT];
  assign is_analog = (in_type == uic_pkg::TYPE_VOLT) || (in_type == uic_pkg::TYPE_CURR);
  assign is_dig    = (in_type == uic_pkg::TYPE_DIG);
  assign is_pulse  = (in_type == uic_pkg::TYPE_FREQ) || (in_type == uic_pkg::TYPE_PWM);

  // bus slave: one wait cycle, then ack
  assign wr_go           = avs_write && ack_r;
  assign rd_go           = avs_read && !ack_r;
  assign avs_waitrequest = (avs_read || avs_write) && !ack_r;

  genvar gb;
  generate
    for (gb = 0; gb < 4; gb++)
    begin : g_be
      assign wmask[gb*8 +: 8] = {8{avs_byteenable[gb]}};
    end
  endgenerate

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      ack_r <= 1'b0;
    else
      ack_r <= (avs_read || avs_write) && !ack_r;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      cfg_r      <= uic_pkg::CFG_RST;
      deb_r      <= uic_pkg::DEB_RST;
      ppr_r      <= '0;
      fconst_r   <= uic_pkg::FCONST_RST;
      rmin_r     <= '0;
      rmax_r     <= '0;
      emin_r     <= '0;
      emax_r     <= '0;
      hyst_r     <= '0;
      edly_r     <= '0;
      irq_mask_r <= '0;
    end
    else if (wr_go)
    begin
      if (avs_address == uic_pkg::OFF_CFG)
        cfg_r <= (cfg_r & ~wmask) | (avs_writedata & wmask);
      else if (avs_address == uic_pkg::OFF_DEB)
        deb_r <= (deb_r & ~wmask) | (avs_writedata & wmask);
      else if (avs_address == uic_pkg::OFF_PPR)
        ppr_r <= (ppr_r & ~wmask) | (avs_writedata & wmask);
      else if (avs_address == uic_pkg::OFF_FCONST)
        fconst_r <= (fconst_r & ~wmask) | (avs_writedata & wmask);
      else if (avs_address == uic_pkg::OFF_RMIN)
        rmin_r <= (rmin_r & ~wmask) | (avs_writedata & wmask);
      else if (avs_address == uic_pkg::OFF_RMAX)
        rmax_r <= (rmax_r & ~wmask) | (avs_writedata & wmask);
      else if (avs_address == uic_pkg::OFF_EMIN)
        emin_r <= (emin_r & ~wmask) | (avs_writedata & wmask);
      else if (avs_address == uic_pkg::OFF_EMAX)
        emax_r <= (emax_r & ~wmask) | (avs_writedata & wmask);
      else if (avs_address == uic_pkg::OFF_HYST)
        hyst_r <= (hyst_r & ~wmask) | (avs_writedata & wmask);
      else if (avs_address == uic_pkg::OFF_EDLY)
        edly_r <= (edly_r & ~wmask) | (avs_writedata & wmask);
      else if (avs_address == uic_pkg::OFF_MASK)
        irq_mask_r <= (irq_mask_r & ~wmask[2:0]) | (avs_writedata[2:0] & wmask[2:0]);
    end
  end

  // error delay fans out to every diagnostic
  genvar gd;
  generate
    for (gd = 0; gd < NDIAG; gd++)
    begin : g_diag
      assign diag_delay[gd*32 +: 32] = edly_r;
    end
  endgenerate

  // analog front end and pull network
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      adc_en       <= 1'b0;
      adc_notch    <= 2'h0;
      pull_up_en   <= 1'b0;
      pull_down_en <= 1'b0;
    end
    else
    begin
      adc_en       <= is_analog;
      adc_notch    <= is_analog ? cfg_r[uic_pkg::CFG_AFILT_LSB +: 2] : 2'h0;
      pull_up_en   <= is_dig && (cfg_r[uic_pkg::CFG_PULL_LSB +: 2] == uic_pkg::PULL_UP);
      pull_down_en <= is_dig && (cfg_r[uic_pkg::CFG_PULL_LSB +: 2] == uic_pkg::PULL_DOWN);
    end
  end

  // 1 ms tick
  logic [31:0] tick_cnt_r;
  logic        tick;
  assign tick = (tick_cnt_r == 32'(TICK_CYC - 1));
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n || tick)
      tick_cnt_r <= '0;
    else
      tick_cnt_r <= tick_cnt_r + 32'h1;
  end

  // pin synchroniser
  logic pin_s1_r;
  logic pin_s2_r;
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      pin_s1_r <= 1'b0;
      pin_s2_r <= 1'b0;
    end
    else
    begin
      pin_s1_r <= pin_in;
      pin_s2_r <= pin_s1_r;
    end
  end

  // pulse filter lengths and digital debounce share one filter
  logic [15:0] flt_len;
  logic        cond;
  always_comb
  begin
    flt_len = 16'h1;
    if (is_dig)
      flt_len = deb_r[15:0];
    else if (pwmf == 2'h1)
      flt_len = 16'(uic_pkg::PWMF1_CYC);
    else if (pwmf == 2'h2)
      flt_len = 16'(uic_pkg::PWMF2_CYC);
    else if (pwmf == 2'h3)
      flt_len = 16'(uic_pkg::PWMF3_CYC);
  end

  uic_glitch #(.CW(16)) u_glitch (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .din     (pin_s2_r),
    .len     (flt_len),
    .dout    (cond)
  );

  logic [31:0] freq_val;
  logic        freq_done;
  uic_freq u_freq (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .en      (is_pulse),
    .sig     (cond),
    .tick    (tick),
    .ppr     (ppr_r[15:0]),
    .freq    (freq_val),
    .done    (freq_done)
  );

  // logic interpretation
  logic cond_d_r;
  logic lat_r;
  logic state_nxt;
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      cond_d_r <= 1'b0;
      lat_r    <= 1'b0;
    end
    else
    begin
      cond_d_r <= cond;
      if (logic_sel == uic_pkg::LOGIC_LAT && cond && !cond_d_r)
        lat_r <= ~lat_r;
      else if (logic_sel == uic_pkg::LOGIC_INVLAT && !cond && cond_d_r)
        lat_r <= ~lat_r;
    end
  end

  always_comb
  begin
    case (logic_sel)
      uic_pkg::LOGIC_NORM:   state_nxt = cond;
      uic_pkg::LOGIC_INV:    state_nxt = ~cond;
      uic_pkg::LOGIC_LAT:    state_nxt = lat_r;
      uic_pkg::LOGIC_INVLAT: state_nxt = lat_r;
      default:               state_nxt = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      state_out <= 1'b0;
    else
      state_out <= is_dig && state_nxt;
  end

  // data filter
  logic [31:0] samp_r;
  logic [47:0] sum_r;
  logic [31:0] navg_r;
  logic [31:0] fc;
  assign fc = (fconst_r == 32'h0) ? 32'h1 : fconst_r;
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      samp_r <= '0;
    else if (meas_valid && is_analog)
      samp_r <= meas_data;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      value_out <= '0;
      sum_r     <= '0;
      navg_r    <= '0;
    end
    else if (is_pulse)
    begin
      if (freq_done)
        value_out <= freq_val;
    end
    else if (!is_analog)
    begin
      value_out <= '0;
      sum_r     <= '0;
      navg_r    <= '0;
    end
    else if (dfilt == uic_pkg::DFILT_MAVG)
    begin
      if (tick)
        value_out <= 32'($signed({1'b0, value_out}) +
                     ($signed({1'b0, samp_r}) - $signed({1'b0, value_out})) / $signed({1'b0, fc}));
    end
    else if (dfilt == uic_pkg::DFILT_RAVG)
    begin
      if (tick && navg_r + 32'h1 >= fc)
      begin
        value_out <= 32'((sum_r + {16'h0, samp_r}) / {16'h0, fc});
        sum_r     <= '0;
        navg_r    <= '0;
      end
      else if (tick)
      begin
        sum_r  <= sum_r + {16'h0, samp_r};
        navg_r <= navg_r + 32'h1;
      end
    end
    else
      value_out <= samp_r;
  end

  // error with hysteresis
  logic err_lo_r;
  logic err_hi_r;
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n || !err_en || !(is_analog || is_pulse))
    begin
      err_lo_r <= 1'b0;
      err_hi_r <= 1'b0;
    end
    else
    begin
      if (value_out < emin_r)
        err_lo_r <= 1'b1;
      else if (value_out >= emin_r + hyst_r)
        err_lo_r <= 1'b0;
      if (value_out > emax_r)
        err_hi_r <= 1'b1;
      else if (value_out + hyst_r <= emax_r)
        err_hi_r <= 1'b0;
    end
  end
  assign err_out = err_lo_r | err_hi_r;

  // sticky events, write one to clear, set wins
  logic       st_d_r;
  logic       err_d_r;
  logic [2:0] ev;
  assign ev = {tick && is_analog, err_out && !err_d_r, state_out != st_d_r};
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      st_d_r   <= 1'b0;
      err_d_r  <= 1'b0;
      irq_st_r <= '0;
    end
    else
    begin
      st_d_r  <= state_out;
      err_d_r <= err_out;
      if (wr_go && avs_address == uic_pkg::OFF_IRQ)
        irq_st_r <= (irq_st_r & ~(avs_writedata[2:0] & wmask[2:0])) | ev;
      else
        irq_st_r <= irq_st_r | ev;
    end
  end
  assign irq = |(irq_st_r & irq_mask_r);

  // read mux
  always_comb
  begin
    rd_nxt = 32'h0;
    if (avs_address == uic_pkg::OFF_CFG)
      rd_nxt = cfg_r;
    else if (avs_address == uic_pkg::OFF_DEB)
      rd_nxt = deb_r;
    else if (avs_address == uic_pkg::OFF_PPR)
      rd_nxt = ppr_r;
    else if (avs_address == uic_pkg::OFF_FCONST)
      rd_nxt = fconst_r;
    else if (avs_address == uic_pkg::OFF_RMIN)
      rd_nxt = rmin_r;
    else if (avs_address == uic_pkg::OFF_RMAX)
      rd_nxt = rmax_r;
    else if (avs_address == uic_pkg::OFF_EMIN)
      rd_nxt = emin_r;
    else if (avs_address == uic_pkg::OFF_EMAX)
      rd_nxt = emax_r;
    else if (avs_address == uic_pkg::OFF_HYST)
      rd_nxt = hyst_r;
    else if (avs_address == uic_pkg::OFF_EDLY)
      rd_nxt = edly_r;
    else if (avs_address == uic_pkg::OFF_VALUE)
      rd_nxt = value_out;
    else if (avs_address == uic_pkg::OFF_STAT)
      rd_nxt = {29'h0, err_hi_r, err_lo_r, state_out};
    else if (avs_address == uic_pkg::OFF_IRQ)
      rd_nxt = {29'h0, irq_st_r};
    else if (avs_address == uic_pkg::OFF_MASK)
      rd_nxt = {29'h0, irq_mask_r};
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      avs_readdata <= '0;
    else if (rd_go)
      avs_readdata <= rd_nxt;
  end

  dig_adc_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    is_dig |=> !adc_en) else $error("adc enabled in digital type");
  notch_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !is_analog |=> adc_notch == 2'h0) else $error("notch outside analog");
  pull_mux_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !is_dig |=> !pull_up_en && !pull_down_en) else $error("pull outside digital");
  norm_state_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    is_dig && logic_sel == uic_pkg::LOGIC_NORM |=> state_out == $past(cond)) else $error("normal state wrong");
  inv_state_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    is_dig && logic_sel == uic_pkg::LOGIC_INV |=> state_out == !$past(cond)) else $error("inverse state wrong");
  latch_tog_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    logic_sel == uic_pkg::LOGIC_LAT && cond && !cond_d_r |=> lat_r != $past(lat_r)) else $error("latch missed");
  ilatch_tog_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    logic_sel == uic_pkg::LOGIC_INVLAT && !cond && cond_d_r |=> lat_r != $past(lat_r)) else $error("ilatch missed");
  raw_value_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    is_analog && dfilt == uic_pkg::DFILT_NONE ##1 is_analog && dfilt == uic_pkg::DFILT_NONE
    |=> value_out == $past(samp_r)) else $error("raw value stale");
  err_gate_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !err_en |=> !err_out) else $error("error without enable");
  delay_fan_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    diag_delay[NDIAG*32-1 -: 32] == edly_r) else $error("delay not copied");
endmodule
`default_nettype wire

// *** uic_pkg.sv ***
package uic_pkg;
  // input type codes
  localparam logic [2:0] TYPE_OFF  = 3'h0;
  localparam logic [2:0] TYPE_VOLT = 3'h1;
  localparam logic [2:0] TYPE_CURR = 3'h2;
  localparam logic [2:0] TYPE_DIG  = 3'h3;
  localparam logic [2:0] TYPE_FREQ = 3'h4;
  localparam logic [2:0] TYPE_PWM  = 3'h5;
  // logic interpretation codes
  localparam logic [2:0] LOGIC_NONE   = 3'h0;
  localparam logic [2:0] LOGIC_NORM   = 3'h1;
  localparam logic [2:0] LOGIC_INV    = 3'h2;
  localparam logic [2:0] LOGIC_LAT    = 3'h3;
  localparam logic [2:0] LOGIC_INVLAT = 3'h4;
  // data filter codes
  localparam logic [1:0] DFILT_NONE = 2'h0;
  localparam logic [1:0] DFILT_MAVG = 2'h1;
  localparam logic [1:0] DFILT_RAVG = 2'h2;
  // pull codes
  localparam logic [1:0] PULL_UP   = 2'h1;
  localparam logic [1:0] PULL_DOWN = 2'h2;
  // register offsets
  localparam logic [5:0] OFF_CFG    = 6'h00;
  localparam logic [5:0] OFF_DEB    = 6'h04;
  localparam logic [5:0] OFF_PPR    = 6'h08;
  localparam logic [5:0] OFF_FCONST = 6'h0c;
  localparam logic [5:0] OFF_RMIN   = 6'h10;
  localparam logic [5:0] OFF_RMAX   = 6'h14;
  localparam logic [5:0] OFF_EMIN   = 6'h18;
  localparam logic [5:0] OFF_EMAX   = 6'h1c;
  localparam logic [5:0] OFF_HYST   = 6'h20;
  localparam logic [5:0] OFF_EDLY   = 6'h24;
  localparam logic [5:0] OFF_VALUE  = 6'h28;
  localparam logic [5:0] OFF_STAT   = 6'h2c;
  localparam logic [5:0] OFF_IRQ    = 6'h30;
  localparam logic [5:0] OFF_MASK   = 6'h34;
  // cfg fields
  localparam int CFG_TYPE_LSB  = 0;
  localparam int CFG_AFILT_LSB = 4;
  localparam int CFG_PULL_LSB  = 6;
  localparam int CFG_LOGIC_LSB = 8;
  localparam int CFG_PWMF_LSB  = 12;
  localparam int CFG_DFILT_LSB = 14;
  localparam int CFG_ERREN_BIT = 16;
  // reset values
  localparam logic [31:0] CFG_RST    = 32'h0000_0110;
  localparam logic [31:0] FCONST_RST = 32'h0000_0004;
  localparam logic [31:0] DEB_RST    = 32'h0000_0004;
  // timing
  localparam int CLK_MHZ     = 250;
  localparam int TICK_US     = 1000;
  localparam int TICK_CYC    = TICK_US * CLK_MHZ;
  localparam int PWMF1_NS    = 111;
  localparam int PWMF2_NS    = 1780;
  localparam int PWMF3_NS    = 14220;
  localparam int PWMF1_CYC   = (PWMF1_NS * CLK_MHZ + 999) / 1000;
  localparam int PWMF2_CYC   = (PWMF2_NS * CLK_MHZ + 999) / 1000;
  localparam int PWMF3_CYC   = (PWMF3_NS * CLK_MHZ + 999) / 1000;
  // irq bits
  localparam int IRQ_STATE = 0;
  localparam int IRQ_ERR   = 1;
  localparam int IRQ_SAMP  = 2;
endpackage

// *** uic_glitch.sv ***
`timescale 1ns/1ps
`default_nettype none
// holds a new level only after it stays put for len cycles
module uic_glitch #(
  parameter int CW = 16
) (
  input  wire logic          sys_clk,
  input  wire logic          rst_n,
  input  wire logic          din,
  input  wire logic [CW-1:0] len,
  output logic               dout
);
  logic [CW-1:0] cnt_r;

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      cnt_r <= '0;
      dout  <= 1'b0;
    end
    else if (din == dout)
      cnt_r <= '0;
    else if (cnt_r + 1'b1 >= len)
    begin
      cnt_r <= '0;
      dout  <= din;
    end
    else
      cnt_r <= cnt_r + 1'b1;
  end
endmodule
`default_nettype wire

// *** uic_freq.sv ***
`timescale 1ns/1ps
`default_nettype none
// counts rising edges per 1 s window (1000 ticks), scales by 60/ppr when ppr>0
module uic_freq (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        en,
  input  wire logic        sig,
  input  wire logic        tick,
  input  wire logic [15:0] ppr,
  output logic [31:0]      freq,
  output logic             done
);
  logic        sig_d_r;
  logic [31:0] edges_r;
  logic [9:0]  ms_r;
  logic [31:0] rpm;

  assign rpm = (ppr == 16'h0) ? edges_r : (edges_r * 32'h3c) / {16'h0, ppr};

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      sig_d_r <= 1'b0;
      edges_r <= '0;
      ms_r    <= '0;
      freq    <= '0;
      done    <= 1'b0;
    end
    else
    begin
      sig_d_r <= sig;
      done    <= 1'b0;
      if (!en)
      begin
        edges_r <= '0;
        ms_r    <= '0;
      end
      else if (tick && ms_r == 10'd999)
      begin
        freq    <= rpm;
        done    <= 1'b1;
        edges_r <= {31'h0, sig & ~sig_d_r};
        ms_r    <= '0;
      end
      else
      begin
        if (sig & ~sig_d_r)
          edges_r <= edges_r + 32'h1;
        if (tick)
          ms_r <= ms_r + 10'd1;
      end
    end
  end
endmodule
`default_nettype wire

// *** uic_sensor.sv ***
`timescale 1ns/1ps
`default_nettype none
// switch or sensor on the far side: level, square wave, converter samples
module uic_sensor (
  input  wire logic        sys_clk,
  input  wire logic        lvl,
  input  wire logic [15:0] half,
  input  wire logic [31:0] samp,
  output logic             pin_in,
  output logic [31:0]      meas_data,
  output logic             meas_valid
);
  logic [15:0] cnt_r = '0;
  logic [2:0]  mcnt_r = '0;
  logic        sq_r = 1'b0;
  // square wave when half is nonzero, else plain level
  always_ff @(posedge sys_clk)
  begin
    cnt_r <= (cnt_r + 16'h1 >= half) ? 16'h0 : cnt_r + 16'h1;
    if (half != 16'h0 && cnt_r + 16'h1 >= half)
      sq_r <= !sq_r;
  end
  assign pin_in = (half != 16'h0) ? sq_r : lvl;
  // one sample every 8 cycles, data not held between pulses
  always_ff @(posedge sys_clk)
  begin
    mcnt_r     <= mcnt_r + 3'h1;
    meas_valid <= (mcnt_r == 3'h7);
    meas_data  <= (mcnt_r == 3'h7) ? samp : ~samp;
  end
endmodule
`default_nettype wire

// *** universal_input_conditioning_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module universal_input_conditioning_tb;
  logic        sys_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [5:0]  avs_address = '0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = '0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        pin_in;
  logic [31:0] meas_data;
  logic        meas_valid;
  logic        adc_en;
  logic [1:0]  adc_notch;
  logic        pull_up_en;
  logic        pull_down_en;
  logic        state_out;
  logic [31:0] value_out;
  logic        err_out;
  logic [63:0] diag_delay;
  logic        irq;
  logic        lvl = 1'b0;
  logic [15:0] half = '0;
  logic [31:0] samp = '0;
  int          errors = 0;
  int          comparisons = 0;
  always #2 sys_clk = !sys_clk;
  uic_top #(.NDIAG(2), .TICK_CYC(10)) i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .pin_in(pin_in), .meas_data(meas_data),
    .meas_valid(meas_valid), .adc_en(adc_en), .adc_notch(adc_notch), .pull_up_en(pull_up_en),
    .pull_down_en(pull_down_en), .state_out(state_out), .value_out(value_out), .err_out(err_out),
    .diag_delay(diag_delay), .irq(irq));
  uic_sensor i_sen (.sys_clk(sys_clk), .lvl(lvl), .half(half), .samp(samp), .pin_in(pin_in),
    .meas_data(meas_data), .meas_valid(meas_valid));
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic close_out();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      errors++;
      $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_rng(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
    comparisons++;
    if ($isunknown(got) || !(got >= lo && got <= hi))
    begin
      errors++;
      $display("CHECK FAILED %0t value %h out of range", $time, got);
    end
  endtask
  // one bus cycle, entered just after a rising edge
  task automatic av(input logic [5:0] a, input logic w, input logic [31:0] d, output logic [31:0] q);
    avs_address   <= a;
    avs_write     <= w;
    avs_read      <= !w;
    avs_writedata <= d;
    @(posedge sys_clk);
    while (avs_waitrequest !== 1'b0)
      @(posedge sys_clk);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    cyc(1);
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] q;
    av(a, 1'b1, d, q);
  endtask
  task automatic rd_chk(input logic [5:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] q;
    av(a, 1'b0, 32'h0, q);
    chk(q & m, e);
  endtask
  function automatic logic [31:0] cfg(input logic [2:0] ty, input logic [1:0] af, input logic [1:0] pl,
    input logic [2:0] lg, input logic [1:0] pf, input logic [1:0] df, input logic ee);
    return {15'h0, ee, df, pf, 1'b0, lg, pl, af, 1'b0, ty};
  endfunction
  task automatic do_rst();
    rst_n <= 1'b0;
    cyc(2);
    rst_n <= 1'b1;
    cyc(1);
  endtask
  task automatic wait_chg(input logic [31:0] old);
    int n;
    n = 0;
    while (value_out === old && n < 300)
    begin
      cyc(1);
      n++;
    end
  endtask
  task automatic t_reset();
    rd_chk(uic_pkg::OFF_CFG, 32'hffffffff, uic_pkg::CFG_RST);
    rd_chk(uic_pkg::OFF_FCONST, 32'hffffffff, uic_pkg::FCONST_RST);
    wr(6'h3c, 32'h5a5a);
    rd_chk(6'h3c, 32'hffffffff, 32'h0);
  endtask
  task automatic t_type();
    logic an;
    for (int t = 0; t < 6; t++)
    begin
      an = (t == 1 || t == 2);
      wr(uic_pkg::OFF_CFG, cfg(t[2:0], 2'h3, 2'h1, 3'h1, 2'h0, 2'h0, 1'b0));
      cyc(2);
      chk(adc_en, an);
      chk(adc_notch, an ? 2'h3 : 2'h0);
      chk(pull_up_en, t == 3);
    end
    for (int p = 0; p < 3; p++)
    begin
      wr(uic_pkg::OFF_CFG, cfg(uic_pkg::TYPE_DIG, 2'h0, p[1:0], 3'h1, 2'h0, 2'h0, 1'b0));
      cyc(2);
      chk({pull_down_en, pull_up_en}, p);
    end
  endtask
  task automatic t_logic();
    logic s0;
    logic [1:0] e;
    for (int g = 1; g < 5; g++)
    begin
      wr(uic_pkg::OFF_CFG, cfg(uic_pkg::TYPE_DIG, 2'h0, 2'h0, g[2:0], 2'h0, 2'h0, 1'b0));
      cyc(30);
      s0 = state_out;
      e = (g == 1) ? 2'b10 : (g == 2) ? 2'b01 : (g == 3) ? {!s0, !s0} : {s0, !s0};
      lvl <= 1'b1;
      cyc(30);
      chk(state_out, e[1]);
      lvl <= 1'b0;
      cyc(30);
      chk(state_out, e[0]);
    end
    wr(uic_pkg::OFF_CFG, cfg(uic_pkg::TYPE_DIG, 2'h0, 2'h0, 3'h1, 2'h0, 2'h0, 1'b0));
    lvl <= 1'b1;
    cyc(2);
    lvl <= 1'b0;
    cyc(30);
    chk(state_out, 1'b0);
  endtask
  task automatic t_filt();
    do_rst();
    samp <= 32'd100;
    wr(uic_pkg::OFF_FCONST, 32'h2);
    wr(uic_pkg::OFF_CFG, cfg(uic_pkg::TYPE_VOLT, 2'h1, 2'h0, 3'h1, 2'h0, uic_pkg::DFILT_MAVG, 1'b0));
    wait_chg(32'd0);
    chk(value_out, 32'd50);
    wait_chg(32'd50);
    chk(value_out, 32'd75);
    samp <= 32'd40;
    wr(uic_pkg::OFF_CFG, cfg(uic_pkg::TYPE_VOLT, 2'h1, 2'h0, 3'h1, 2'h0, uic_pkg::DFILT_RAVG, 1'b0));
    cyc(100);
    chk(value_out, 32'd40);
    samp <= 32'd7;
    wr(uic_pkg::OFF_CFG, cfg(uic_pkg::TYPE_VOLT, 2'h1, 2'h0, 3'h1, 2'h0, uic_pkg::DFILT_NONE, 1'b0));
    cyc(20);
    chk(value_out, 32'd7);
  endtask
  task automatic t_err();
    logic i0;
    wr(uic_pkg::OFF_EMIN, 32'd100);
    wr(uic_pkg::OFF_EMAX, 32'd1000);
    wr(uic_pkg::OFF_HYST, 32'd10);
    rd_chk(uic_pkg::OFF_EMIN, 32'hffffffff, 32'd100);
    wr(uic_pkg::OFF_RMAX, 32'd900);
    rd_chk(uic_pkg::OFF_RMAX, 32'hffffffff, 32'd900);
    samp <= 32'd50;
    cyc(30);
    chk(err_out, 1'b0);
    wr(uic_pkg::OFF_CFG, cfg(uic_pkg::TYPE_VOLT, 2'h1, 2'h0, 3'h1, 2'h0, 2'h0, 1'b1));
    cyc(30);
    chk(err_out, 1'b1);
    rd_chk(uic_pkg::OFF_IRQ, 32'h2, 32'h2);
    wr(uic_pkg::OFF_MASK, 32'h0);
    i0 = irq;
    wr(uic_pkg::OFF_MASK, 32'h7);
    chk(i0 ^ irq, 1'b1);
    samp <= 32'd105;
    cyc(30);
    chk(err_out, 1'b1);
    samp <= 32'd110;
    cyc(30);
    chk(err_out, 1'b0);
    wr(uic_pkg::OFF_IRQ, 32'h7);
    rd_chk(uic_pkg::OFF_IRQ, 32'h2, 32'h0);
    samp <= 32'd1001;
    cyc(30);
    chk(err_out, 1'b1);
    samp <= 32'd990;
    cyc(30);
    chk(err_out, 1'b0);
    wr(uic_pkg::OFF_EDLY, 32'h1234);
    chk(diag_delay[31:0], 32'h1234);
    chk(diag_delay[63:32], 32'h1234);
  endtask
  task automatic t_freq();
    wr(uic_pkg::OFF_PPR, 32'd3);
    wr(uic_pkg::OFF_CFG, cfg(uic_pkg::TYPE_FREQ, 2'h0, 2'h0, 3'h1, 2'h1, 2'h0, 1'b0));
    half <= 16'd40;
    cyc(21000);
    chk_rng(value_out, 32'd2480, 32'd2520);
    wr(uic_pkg::OFF_CFG, cfg(uic_pkg::TYPE_FREQ, 2'h0, 2'h0, 3'h1, 2'h2, 2'h0, 1'b0));
    cyc(21000);
    chk(value_out, 32'd0);
    half <= 16'd0;
  endtask
  initial
  begin
    #300000;
    errors++;
    close_out();
  end
  initial
  begin
    cyc(2);
    rst_n <= 1'b1;
    cyc(1);
    t_reset();
    t_type();
    t_logic();
    t_filt();
    t_err();
    t_freq();
    close_out();
  end
endmodule
`default_nettype wire
